/* verilog/t16_core.sv */
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "t16_regs.svh"

// How it works
// R1: count, compares, capture are 16-bit byte halves
// R2: two 8-bit control registers, single access
// R3: every request shows in flags, masked per bit
// R4: clock select picks source and edge tick
// R5: no source selected, counter stands still
// R6: compares checked continuously, match sets flag
// R7: masked compare flag raises interrupt request
// R8: capture edge copies counter to capture
// R9: selectable filter rejects short capture spikes
// R10: compare A as top: buffered, no output (code buffers it in pwm modes only; CTC with A as top loads it at once)
// R11: bottom flag when counter is zero
// R12: max flag when counter is all ones
// R13: top from fixed value, compare A, capture
// R14: one shared high byte holding register
// R15: low byte write loads whole word at once
// R16: low byte read latches high byte
// R17: compare reads bypass the holding register
// R18: master writes high first, reads low first
// R19: master keeps byte pair atomic vs interrupts
// R20: bus counter write beats counting
// R21: reset clears holding, counter, compare, capture
module t16_core (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus
	input wire t16_pkg::t16_av_req_s av_req,
	output t16_pkg::t16_av_rsp_s av_rsp,
	// pins
	input wire logic external_count_pin,
	input wire logic capture_input_pin,
	input wire logic comparator_out,
	// status and requests
	output logic [3:0] irq_req,
	output logic cmp_out_a,
	output logic cmp_out_b,
	output logic at_bottom,
	output logic at_max,
	output logic at_top
);

	t16_pkg::t16_core_s st_q;
	t16_pkg::t16_core_s st_d;
	logic timer_tick;
	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;
	logic cap_evt;
	logic cap_raw;
	logic take;
	logic rd;
	logic wr;
	logic [7:0] wdat;
	logic [7:0] rbyte;
	logic [3:0] mode;
	logic [15:0] top;
	logic a_top;
	logic i_top;
	logic pwm;
	logic [7:0] cnt_hi;

	// ****************************************
	// clock source and pin paths
	// ****************************************
	// source mux ahead of the sync: switching source may fake a capture
	assign cap_raw = st_q.ctrl_a[`T16_CA_CAPSRC] ? comparator_out : capture_input_pin;

	t16_pin_sync u_ext_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(external_count_pin),
		.filter_en(1'b0),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	t16_pin_sync u_cap_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin(cap_raw),
		.filter_en(st_q.ctrl_b[`T16_CB_FILT]),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	t16_clk_select u_clk_sel (
		.clk(clk),
		.sys_rst(sys_rst),
		.cs(st_q.ctrl_b[`T16_CB_CS]),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall),
		.tick(timer_tick)
	);

	// ****************************************
	// mode decode
	// ****************************************
	assign mode = {st_q.ctrl_b[`T16_CB_WGM], st_q.ctrl_a[`T16_CA_WGM]};
	assign a_top = mode == `T16_M_CTC_A || mode == `T16_M_PFC_A || mode == `T16_M_PC_A || mode == `T16_M_F_A;
	assign i_top = mode == `T16_M_CTC_I || mode == `T16_M_PFC_I || mode == `T16_M_PC_I || mode == `T16_M_F_I;
	assign pwm = !(mode == `T16_M_NORMAL || mode == `T16_M_CTC_A || mode == `T16_M_CTC_I || mode == `T16_M_RSVD);
	assign cnt_hi = st_q.cnt[`T16_HIGH];
	// capture unit is idle while the capture word defines top
	assign cap_evt = !i_top && (st_q.ctrl_b[`T16_CB_EDGE] ? cap_rise : cap_fall); // R8

	// top of the count sequence
	always_comb begin
		top = `T16_MAX;
		case (mode)
			`T16_M_PC8, `T16_M_F8: top = `T16_TOP8; // R13
			`T16_M_PC9, `T16_M_F9: top = `T16_TOP9; // R13
			`T16_M_PC10, `T16_M_F10: top = `T16_TOP10; // R13
			`T16_M_CTC_A, `T16_M_PFC_A, `T16_M_PC_A, `T16_M_F_A: top = st_q.cmpa_act; // R13
			`T16_M_CTC_I, `T16_M_PFC_I, `T16_M_PC_I, `T16_M_F_I: top = st_q.cap; // R13
			default: top = `T16_MAX;
		endcase
	end

	// ****************************************
	// bus request decode
	// ****************************************
	// a request is taken once, in the idle state; the ack cycle ignores it
	assign take = st_q.bus == t16_pkg::T16_BUS_IDLE && (av_req.read || av_req.write);
	assign rd = take && av_req.read;
	assign wr = take && av_req.write && av_req.byteenable[0];
	assign wdat = av_req.writedata[`T16_BYTE];

	// read mux; high halves of count and capture come from the holding byte
	always_comb begin
		rbyte = 8'h00;
		case (av_req.address)
			`T16_OFS_CTRL_A: rbyte = st_q.ctrl_a; // R2
			`T16_OFS_CTRL_B: rbyte = st_q.ctrl_b; // R2
			`T16_OFS_CNT_L: rbyte = st_q.cnt[`T16_BYTE]; // R1
			`T16_OFS_CNT_H: rbyte = st_q.temp; // R16
			`T16_OFS_CMPA_L: rbyte = st_q.cmpa_buf[`T16_BYTE];
			`T16_OFS_CMPA_H: rbyte = st_q.cmpa_buf[`T16_HIGH]; // R17
			`T16_OFS_CMPB_L: rbyte = st_q.cmpb_buf[`T16_BYTE];
			`T16_OFS_CMPB_H: rbyte = st_q.cmpb_buf[`T16_HIGH]; // R17
			`T16_OFS_CAP_L: rbyte = st_q.cap[`T16_BYTE]; // R1
			`T16_OFS_CAP_H: rbyte = st_q.temp; // R16
			`T16_OFS_FLAG: rbyte = 8'(st_q.flags); // R3
			`T16_OFS_MASK: rbyte = 8'(st_q.mask); // R3
			default: rbyte = 8'h00;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_d = st_q;
		// bus handshake: action at the taking edge, answer one cycle later
		case (st_q.bus)
			t16_pkg::T16_BUS_IDLE: begin
				if (take) begin
					st_d.bus = t16_pkg::T16_BUS_ACK;
					st_d.waitreq = 1'b0;
					st_d.rdata = rd ? 32'(rbyte) : '0;
				end
			end
			t16_pkg::T16_BUS_ACK: begin
				st_d.bus = t16_pkg::T16_BUS_IDLE;
				st_d.waitreq = 1'b1;
			end
			default: begin
				st_d.bus = t16_pkg::T16_BUS_IDLE;
				st_d.waitreq = 1'b1;
			end
		endcase

		// counting; wraps at top, overflow flagged on the wrap
		if (timer_tick) begin
			if (st_q.cnt == top) begin
				st_d.cnt = `T16_BOTTOM;
			end else begin
				st_d.cnt = st_q.cnt + `T16_ONE; // R4
			end
		end

		// compare buffers follow software at once, or only at top in pwm modes
		if (!pwm || (timer_tick && st_q.cnt == top)) begin
			st_d.cmpa_act = st_q.cmpa_buf; // R10
			st_d.cmpb_act = st_q.cmpb_buf;
		end

		// flag clear by writing one; sets below come after, so a set wins
		if (wr && av_req.address == `T16_OFS_FLAG) begin
			st_d.flags = st_q.flags & ~wdat[`T16_F_ALL]; // R3
		end
		if (timer_tick && st_q.cnt == top) begin
			st_d.flags[`T16_F_OVF] = 1'b1; // R3
		end
		if (timer_tick && st_q.cnt == st_q.cmpa_act) begin
			st_d.flags[`T16_F_CMPA] = 1'b1; // R6
		end
		if (timer_tick && st_q.cnt == st_q.cmpb_act) begin
			st_d.flags[`T16_F_CMPB] = 1'b1; // R6
		end
		if (cap_evt) begin
			st_d.cap = st_q.cnt; // R8
			st_d.flags[`T16_F_CAP] = 1'b1; // R8
		end

		// low byte reads latch the high half into the shared byte
		if (rd && av_req.address == `T16_OFS_CNT_L) begin
			st_d.temp = st_q.cnt[`T16_HIGH]; // R16
		end
		if (rd && av_req.address == `T16_OFS_CAP_L) begin
			st_d.temp = st_q.cap[`T16_HIGH]; // R16
		end

		// register writes; relies on the master sending high before low
		if (wr) begin
			case (av_req.address)
				`T16_OFS_CTRL_A: st_d.ctrl_a = wdat; // R2
				`T16_OFS_CTRL_B: st_d.ctrl_b = wdat; // R2
				`T16_OFS_MASK: st_d.mask = wdat[`T16_F_ALL]; // R3
				`T16_OFS_CNT_H, `T16_OFS_CMPA_H, `T16_OFS_CMPB_H, `T16_OFS_CAP_H: st_d.temp = wdat; // R14
				`T16_OFS_CNT_L: st_d.cnt = {st_q.temp, wdat}; // R20
				`T16_OFS_CMPA_L: st_d.cmpa_buf = {st_q.temp, wdat}; // R15
				`T16_OFS_CMPB_L: st_d.cmpb_buf = {st_q.temp, wdat}; // R15
				`T16_OFS_CAP_L: begin
					if (i_top) begin
						st_d.cap = {st_q.temp, wdat}; // R15
					end
				end
				default: st_d.temp = st_q.temp;
			endcase
		end

		// registered status and outputs
		st_d.irq = st_d.flags & st_d.mask; // R7
		st_d.oca = pwm && !a_top && st_d.cnt < st_d.cmpa_act; // R10
		st_d.ocb = pwm && st_d.cnt < st_d.cmpb_act;
		st_d.bottom = st_d.cnt == `T16_BOTTOM; // R11
		st_d.max = st_d.cnt == `T16_MAX; // R12
		st_d.top = st_d.cnt == top; // R13
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0; // R21
			st_q.waitreq <= 1'b1;
			// count is zero in reset, so bottom must already show on the first free edge
			st_q.bottom <= 1'b1; // R11
		end else begin
			st_q <= st_d;
		end
	end

	assign av_rsp = '{readdata: st_q.rdata, waitrequest: st_q.waitreq};
	assign irq_req = st_q.irq;
	assign cmp_out_a = st_q.oca;
	assign cmp_out_b = st_q.ocb;
	assign at_bottom = st_q.bottom;
	assign at_max = st_q.max;
	assign at_top = st_q.top;

	// ****************************************
	// checks
	// ****************************************
	AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (sys_rst) // R5
		(st_q.ctrl_b[`T16_CB_CS] == `T16_CS_OFF && $stable(st_q.ctrl_b) && !(wr && av_req.address == `T16_OFS_CNT_L))
		|=> $stable(st_q.cnt)) else $error("counter moved with no clock");
	AST_BOTTOM_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // R11
		at_bottom == (st_q.cnt == `T16_BOTTOM)) else $error("bottom status wrong");
	AST_MAX_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // R12
		at_max == (st_q.cnt == `T16_MAX)) else $error("max status wrong");
	AST_LOW_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R15
		(wr && av_req.address == `T16_OFS_CMPA_L) |=> st_q.cmpa_buf == {$past(st_q.temp), $past(wdat)})
		else $error("low write did not load word");
	AST_WRITE_WINS: assert property (@(posedge clk) disable iff (sys_rst) // R20
		(wr && av_req.address == `T16_OFS_CNT_L && timer_tick) |=> st_q.cnt == {$past(st_q.temp), $past(wdat)})
		else $error("count beat bus write");
	AST_LOW_READ: assert property (@(posedge clk) disable iff (sys_rst) // R16
		(rd && av_req.address == `T16_OFS_CNT_L) |=> st_q.temp == $past(cnt_hi)) else $error("high byte not latched");
	AST_CMP_READ: assert property (@(posedge clk) disable iff (sys_rst) // R17
		(rd && (av_req.address == `T16_OFS_CMPA_H || av_req.address == `T16_OFS_CMPB_H)) |=> $stable(st_q.temp))
		else $error("compare read touched holding byte");
	AST_IRQ_GATE: assert property (@(posedge clk) disable iff (sys_rst) // R7
		irq_req == (st_q.flags & st_q.mask)) else $error("request not gated by mask");
	AST_CMP_MATCH: assert property (@(posedge clk) disable iff (sys_rst) // R6
		(timer_tick && st_q.cnt == st_q.cmpa_act) |=> st_q.flags[`T16_F_CMPA]) else $error("match flag missed");
	AST_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst) // R8
		cap_evt |=> (st_q.cap == $past(st_q.cnt)) && st_q.flags[`T16_F_CAP]) else $error("capture missed");
	AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (1'b0) // R21
		sys_rst |=> (st_q.cnt == `T16_BOTTOM && st_q.temp == 8'h00 && st_q.cap == `T16_BOTTOM))
		else $error("reset left state");
	AST_A_TOP_QUIET: assert property (@(posedge clk) disable iff (sys_rst) // R10
		a_top |=> !cmp_out_a) else $error("channel A output driven while A is top");
	AST_WRAP_AT_TOP: assert property (@(posedge clk) disable iff (sys_rst) // R13
		(timer_tick && st_q.cnt == top && !(wr && av_req.address == `T16_OFS_CNT_L))
		|=> st_q.cnt == `T16_BOTTOM) else $error("counter did not wrap at top");

endmodule

/* verilog/t16_regs.svh */
`ifndef T16_REGS_SVH
`define T16_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define T16_OFS_CTRL_A 8'h00
`define T16_OFS_CTRL_B 8'h04
`define T16_OFS_CNT_L 8'h08
`define T16_OFS_CNT_H 8'h0C
`define T16_OFS_CMPA_L 8'h10
`define T16_OFS_CMPA_H 8'h14
`define T16_OFS_CMPB_L 8'h18
`define T16_OFS_CMPB_H 8'h1C
`define T16_OFS_CAP_L 8'h20
`define T16_OFS_CAP_H 8'h24
`define T16_OFS_FLAG 8'h28
`define T16_OFS_MASK 8'h2C

// ****************************************
// field positions
// ****************************************
`define T16_CA_WGM 1:0
`define T16_CA_CAPSRC 2
`define T16_CB_CS 2:0
`define T16_CB_WGM 4:3
`define T16_CB_EDGE 6
`define T16_CB_FILT 7
`define T16_F_OVF 0
`define T16_F_CMPA 1
`define T16_F_CMPB 2
`define T16_F_CAP 3
`define T16_F_ALL 3:0
`define T16_BYTE 7:0
`define T16_HIGH 15:8

// ****************************************
// clock select codes
// ****************************************
`define T16_CS_OFF 3'h0
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_CS_EXT_FALL 3'h6
`define T16_CS_EXT_RISE 3'h7
`define T16_PS_M8 10'h007
`define T16_PS_M64 10'h03F
`define T16_PS_M256 10'h0FF
`define T16_PS_M1024 10'h3FF
`define T16_PS_ONE 10'h001

// ****************************************
// counter values and modes
// ****************************************
`define T16_BOTTOM 16'h0000
`define T16_MAX 16'hFFFF
`define T16_ONE 16'h0001
`define T16_TOP8 16'h00FF
`define T16_TOP9 16'h01FF
`define T16_TOP10 16'h03FF
`define T16_M_NORMAL 4'h0
`define T16_M_PC8 4'h1
`define T16_M_PC9 4'h2
`define T16_M_PC10 4'h3
`define T16_M_CTC_A 4'h4
`define T16_M_F8 4'h5
`define T16_M_F9 4'h6
`define T16_M_F10 4'h7
`define T16_M_PFC_I 4'h8
`define T16_M_PFC_A 4'h9
`define T16_M_PC_I 4'hA
`define T16_M_PC_A 4'hB
`define T16_M_CTC_I 4'hC
`define T16_M_RSVD 4'hD
`define T16_M_F_I 4'hE
`define T16_M_F_A 4'hF
`define T16_FILT_ONES 4'hF
`define T16_FILT_ZERO 4'h0

`endif

/* verilog/t16_pkg.sv */
package t16_pkg;

	// ****************************************
	// bus carriers
	// ****************************************
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} t16_av_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} t16_av_rsp_s;

	typedef enum logic {T16_BUS_IDLE, T16_BUS_ACK} t16_bus_e;

	// ****************************************
	// module state
	// ****************************************
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic [3:0] hist;
		logic filt;
		logic prev;
		logic rise;
		logic fall;
	} t16_sync_s;

	typedef struct packed {
		logic [9:0] div;
		logic tick;
	} t16_sel_s;

	typedef struct packed {
		t16_bus_e bus;
		logic waitreq;
		logic [31:0] rdata;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] temp;
		logic [15:0] cnt;
		logic [15:0] cmpa_buf;
		logic [15:0] cmpb_buf;
		logic [15:0] cmpa_act;
		logic [15:0] cmpb_act;
		logic [15:0] cap;
		logic [3:0] flags;
		logic [3:0] mask;
		logic [3:0] irq;
		logic oca;
		logic ocb;
		logic bottom;
		logic max;
		logic top;
	} t16_core_s;

endpackage

/* verilog/t16_pin_sync.sv */
`timescale 1ns/100ps
`include "t16_regs.svh"

module t16_pin_sync (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// pin side
	input wire logic pin,
	input wire logic filter_en,
	// edge pulses
	output logic rise,
	output logic fall
);

	t16_pkg::t16_sync_s st_q;
	t16_pkg::t16_sync_s st_d;
	logic src;

	// ****************************************
	// sync, filter and edge detect
	// ****************************************
	// s1 feeds s2 only; a level counts once s2 and s3 agree
	always_comb begin
		st_d = st_q;
		src = 1'b0;
		st_d.s1 = pin;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3) begin
			st_d.level = st_q.s3;
		end
		// four equal samples needed to move the filtered level
		st_d.hist = {st_q.hist[2:0], st_q.level};
		if (st_q.hist == `T16_FILT_ONES) begin
			st_d.filt = 1'b1; // R9
		end else if (st_q.hist == `T16_FILT_ZERO) begin
			st_d.filt = 1'b0; // R9
		end
		src = filter_en ? st_q.filt : st_q.level;
		st_d.prev = src;
		st_d.rise = src && !st_q.prev;
		st_d.fall = !src && st_q.prev;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rise = st_q.rise;
	assign fall = st_q.fall;

endmodule

/* verilog/t16_clk_select.sv */
`timescale 1ns/100ps
`include "t16_regs.svh"

module t16_clk_select (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// selection
	input wire logic [2:0] cs,
	input wire logic ext_rise,
	input wire logic ext_fall,
	// counter enable
	output logic tick
);

	t16_pkg::t16_sel_s st_q;
	t16_pkg::t16_sel_s st_d;

	// ****************************************
	// free running prescaler and source mux
	// ****************************************
	// prescaler never stops, so a first tick comes 1 to N cycles after enable
	always_comb begin
		st_d = st_q;
		st_d.div = st_q.div + `T16_PS_ONE;
		case (cs)
			`T16_CS_OFF: st_d.tick = 1'b0; // R5
			`T16_CS_DIV1: st_d.tick = 1'b1; // R4
			`T16_CS_DIV8: st_d.tick = (st_q.div & `T16_PS_M8) == `T16_PS_M8;
			`T16_CS_DIV64: st_d.tick = (st_q.div & `T16_PS_M64) == `T16_PS_M64;
			`T16_CS_DIV256: st_d.tick = (st_q.div & `T16_PS_M256) == `T16_PS_M256;
			`T16_CS_DIV1024: st_d.tick = st_q.div == `T16_PS_M1024;
			`T16_CS_EXT_FALL: st_d.tick = ext_fall; // R4
			`T16_CS_EXT_RISE: st_d.tick = ext_rise; // R4
			default: st_d.tick = 1'b0;
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;

	AST_DIV1_TICKS: assert property (@(posedge clk) disable iff (sys_rst) // R4
		(cs == `T16_CS_DIV1) |=> tick) else $error("no tick with system clock selected");

endmodule

/* test/t16_cpu_model.sv */
`timescale 1ns/100ps

// ************************************
// byte-wide master on the register bus
// ************************************
module t16_cpu_model (
	// clock
	input wire logic clk,
	// register bus
	input wire t16_pkg::t16_av_rsp_s av_rsp,
	output t16_pkg::t16_av_req_s av_req
);
	initial av_req = '0;

	// one access: request stays put until waitrequest is seen low; only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		av_req <= '{read: !w, write: w, address: a, writedata: {24'h000000, d}, byteenable: 4'hF};
		do begin
			@(posedge clk);
		end while (av_rsp.waitrequest !== 1'b0);
		q = av_rsp.readdata[7:0];
		av_req <= '0;
	endtask

	// high byte first so the shared holding byte is set before the load; pairs never interleave
	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		logic [7:0] q;
		xfer(1'b1, a + 8'h04, v[15:8], q);
		xfer(1'b1, a, v[7:0], q);
	endtask

	// low byte first: it latches the high byte for the second access
	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		xfer(1'b0, a, 8'h00, v[7:0]);
		xfer(1'b0, a + 8'h04, 8'h00, v[15:8]);
	endtask
endmodule

/* test/tb_top.sv */
`timescale 1ns/100ps
`include "t16_regs.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module tb_top;
	logic clk;
	logic sys_rst;
	logic ecp;
	logic cip;
	logic cmp;
	logic [3:0] irq;
	logic oa;
	logic ob;
	logic ab;
	logic am;
	logic at;
	t16_pkg::t16_av_req_s req;
	t16_pkg::t16_av_rsp_s rsp;
	int n_mismatch = 0;
	int n_compared = 0;

	t16_core dut (.clk(clk), .sys_rst(sys_rst), .av_req(req), .av_rsp(rsp), .external_count_pin(ecp),
		.capture_input_pin(cip), .comparator_out(cmp), .irq_req(irq), .cmp_out_a(oa), .cmp_out_b(ob),
		.at_bottom(ab), .at_max(am), .at_top(at));

	t16_cpu_model cpu (.clk(clk), .av_rsp(rsp), .av_req(req));

	// ************************************
	// helpers
	// ************************************
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		cpu.xfer(1'b1, a, d, q);
	endtask

	task automatic r(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		cpu.xfer(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask

	task automatic r16(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		cpu.rd16(a, v);
		`CHK(v, e)
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// cuts a hang short; the tests need about 11k cycles
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		final_report;
	end

	// ************************************
	// tests
	// ************************************
	initial begin
		int i;
		int nbad;
		int e;
		logic [15:0] v;
		logic [7:0] q;
		sys_rst = 1'b1;
		ecp = 1'b0;
		cip = 1'b0;
		cmp = 1'b0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		r16(`T16_OFS_CNT_L, 16'h0000);
		r16(`T16_OFS_CMPA_L, 16'h0000);
		r16(`T16_OFS_CMPB_L, 16'h0000);
		r16(`T16_OFS_CAP_L, 16'h0000);
		`CHK(ab, 1'b1)
		$display("reset test done");
		// control registers in one access, unmapped reads zero
		w(`T16_OFS_CTRL_A, 8'h04);
		r(`T16_OFS_CTRL_A, 8'h04);
		w(`T16_OFS_CTRL_B, 8'h40);
		r(`T16_OFS_CTRL_B, 8'h40);
		r(8'h30, 8'h00);
		w(`T16_OFS_CTRL_A, 8'h00);
		$display("control test done");
		// stopped counter keeps a written word
		cpu.wr16(`T16_OFS_CNT_L, 16'h1234);
		repeat (20) @(posedge clk);
		r16(`T16_OFS_CNT_L, 16'h1234);
		`CHK(ab, 1'b0)
		// compare read leaves the holding byte alone
		cpu.wr16(`T16_OFS_CMPA_L, 16'hABCD);
		r(`T16_OFS_CNT_L, 8'h34);
		r(`T16_OFS_CMPA_H, 8'hAB);
		r(`T16_OFS_CNT_H, 8'h12);
		// one holding byte serves every word
		w(`T16_OFS_CNT_H, 8'h56);
		w(`T16_OFS_CMPB_L, 8'h78);
		w(`T16_OFS_CNT_L, 8'h9A);
		r16(`T16_OFS_CMPB_L, 16'h5678);
		r16(`T16_OFS_CNT_L, 16'h569A);
		cpu.wr16(`T16_OFS_CNT_L, 16'hFFFF);
		repeat (2) @(posedge clk);
		`CHK(am, 1'b1)
		`CHK(at, 1'b1)
		$display("byte access test done");
		// compare match flags and masked requests
		cpu.wr16(`T16_OFS_CNT_L, 16'h0000);
		cpu.wr16(`T16_OFS_CMPA_L, 16'h0005);
		cpu.wr16(`T16_OFS_CMPB_L, 16'h0007);
		w(`T16_OFS_MASK, 8'h03);
		w(`T16_OFS_FLAG, 8'h0F);
		w(`T16_OFS_CTRL_B, 8'h01);
		repeat (30) @(posedge clk);
		w(`T16_OFS_CTRL_B, 8'h00);
		r(`T16_OFS_FLAG, 8'h06);
		`CHK(irq, 4'h2)
		w(`T16_OFS_FLAG, 8'h02);
		repeat (2) @(posedge clk);
		`CHK(irq, 4'h0)
		// bus write beats the increment of the same cycle
		w(`T16_OFS_CTRL_B, 8'h01);
		cpu.wr16(`T16_OFS_CNT_L, 16'h4000);
		cpu.rd16(`T16_OFS_CNT_L, v);
		`CHK(v[15:8], 8'h40)
		`CHK(v[7:0] < 8'h10, 1'b1)
		w(`T16_OFS_CTRL_B, 8'h00);
		$display("compare test done");
		// prescaler taps; slack covers tap phase and access time
		for (i = 1; i <= 5; i++) begin
			e = 2048 >> ((i == 1) ? 0 : (i == 2) ? 3 : (i == 3) ? 6 : (i == 4) ? 8 : 10);
			cpu.wr16(`T16_OFS_CNT_L, 16'h0000);
			w(`T16_OFS_CTRL_B, i[7:0]);
			repeat (2048) @(posedge clk);
			w(`T16_OFS_CTRL_B, 8'h00);
			cpu.rd16(`T16_OFS_CNT_L, v);
			`CHK((v >= e - 1) && (v <= e + 4), 1'b1)
		end
		// external pin, falling then rising edge
		for (i = 6; i <= 7; i++) begin
			cpu.wr16(`T16_OFS_CNT_L, 16'h0000);
			w(`T16_OFS_CTRL_B, i[7:0]);
			repeat (3) begin
				ecp <= 1'b1;
				repeat (8) @(posedge clk);
				ecp <= 1'b0;
				repeat (8) @(posedge clk);
			end
			w(`T16_OFS_CTRL_B, 8'h00);
			r16(`T16_OFS_CNT_L, 16'h0003);
		end
		$display("clock select test done");
		// fixed top 0x00FF wraps and flags overflow
		w(`T16_OFS_CTRL_A, 8'h01);
		cpu.wr16(`T16_OFS_CNT_L, 16'h00F0);
		w(`T16_OFS_FLAG, 8'h0F);
		w(`T16_OFS_CTRL_B, 8'h01);
		i = 0;
		while (at !== 1'b1 && i < 200) begin
			@(posedge clk);
			i++;
		end
		`CHK(at, 1'b1)
		repeat (20) @(posedge clk);
		w(`T16_OFS_CTRL_B, 8'h00);
		r(`T16_OFS_FLAG, 8'h07);
		`CHK(irq, 4'h3)
		cpu.rd16(`T16_OFS_CNT_L, v);
		`CHK(v < 16'h0100, 1'b1)
		// compare A as top in fast pwm: channel A output stays low
		w(`T16_OFS_CTRL_A, 8'h03);
		w(`T16_OFS_CTRL_B, 8'h19);
		nbad = 0;
		repeat (100) begin
			@(posedge clk);
			if (oa !== 1'b0) nbad++;
		end
		`CHK(nbad, 0)
		cpu.wr16(`T16_OFS_CMPA_L, 16'h0009);
		r16(`T16_OFS_CMPA_L, 16'h0009);
		w(`T16_OFS_CTRL_B, 8'h00);
		w(`T16_OFS_CTRL_A, 8'h00);
		// fixed top fast pwm: outputs high only below their active compare (A 9, loaded at once in normal mode, B 7)
		w(`T16_OFS_CTRL_A, 8'h01);
		w(`T16_OFS_CTRL_B, 8'h08);
		cpu.wr16(`T16_OFS_CNT_L, 16'h0008);
		`CHK(oa, 1'b1)
		`CHK(ob, 1'b0)
		w(`T16_OFS_CTRL_B, 8'h00);
		w(`T16_OFS_CTRL_A, 8'h00);
		$display("top test done");
		// capture with filter: a spike is ignored, a level change is taken
		cpu.wr16(`T16_OFS_CNT_L, 16'h1234);
		w(`T16_OFS_CTRL_B, 8'hC0);
		w(`T16_OFS_FLAG, 8'h0F);
		cip <= 1'b1;
		repeat (2) @(posedge clk);
		cip <= 1'b0;
		repeat (20) @(posedge clk);
		r(`T16_OFS_FLAG, 8'h00);
		cip <= 1'b1;
		repeat (20) @(posedge clk);
		r(`T16_OFS_FLAG, 8'h08);
		r16(`T16_OFS_CAP_L, 16'h1234);
		// comparator as source; flag cleared after the switch
		w(`T16_OFS_CTRL_A, 8'h04);
		cpu.wr16(`T16_OFS_CNT_L, 16'h0777);
		w(`T16_OFS_FLAG, 8'h0F);
		cmp <= 1'b1;
		repeat (20) @(posedge clk);
		r(`T16_OFS_FLAG, 8'h08);
		r16(`T16_OFS_CAP_L, 16'h0777);
		$display("capture test done");
		final_report;
	end
endmodule
